// >>> core/ipc_defs.svh
// register offsets, reset values, vector layout and timing counts of the interrupt controller
`ifndef IPC_DEFS_SVH
`define IPC_DEFS_SVH
`define IPC_NUM_SRC        18
`define IPC_IDX_W          5
`define IPC_OFS_MAIN_EN    8'ha8
`define IPC_OFS_MAIN_PRIO  8'hb8
`define IPC_OFS_EXT_EN_A   8'he6
`define IPC_OFS_EXT_EN_B   8'he7
`define IPC_OFS_EXT_PRIO_A 8'hf6
`define IPC_OFS_EXT_PRIO_B 8'hf7
`define IPC_REG_RESET      8'h00
`define IPC_GLOBAL_EN_BIT  7
`define IPC_MAIN_SRC_CNT   7
`define IPC_EXT_A_SRC_CNT  8
`define IPC_VEC_BASE       16'h0003
`define IPC_VEC_SHIFT      3
`define IPC_DETECT_CYC     1
`define IPC_CALL_CYC       5
`define IPC_RETURN_CYC     6
`define IPC_DIVIDE_CYC     8
`define IPC_MIN_RESP_CYC   (`IPC_DETECT_CYC + `IPC_CALL_CYC)
`define IPC_MAX_RESP_CYC   (`IPC_DETECT_CYC + `IPC_RETURN_CYC + `IPC_DIVIDE_CYC + `IPC_CALL_CYC)
`endif

// >>> core/ipc_pkg.sv
// types shared by the interrupt controller
package ipc_pkg;
  typedef enum logic {LVL_LOW, LVL_HIGH} ipc_level_type;
  typedef struct packed {
    logic          valid;
    ipc_level_type level;
    logic [4:0]    index;
    logic [15:0]   addr;
  } ipc_req_type;
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } ipc_sfr_type;
endpackage

// >>> core/ipc_interrupt_controller.sv
// two-level vectored interrupt controller for an 8-bit core
`timescale 1ns/1ns
`default_nettype none
`include "ipc_defs.svh"
// Overview of operation
// - eighteen sources, each with its own pending flag and entry address.
// - a flag set by software requests exactly like a hardware flag when enabled.
// - an accepted request steers the core to that source's entry address.
// - each source has a priority bit choosing low or high; low after reset.
// - high requests preempt low routines; high routines are never preempted.
// - same-cycle requests at different levels: the high one is serviced first.
// - same-level simultaneous requests are chosen by a fixed hardwired order.
// - pending requests are sampled and priority decoded every clock cycle.
// - minimum response is 6 clocks: 1 detect plus 5 for the far call.
// - request pending at interrupt return waits one more instruction before the call.
// - worst case without competing service is 20 clocks: 1+6+8+5.
// - equal or lower level waits for return plus one following instruction.
// - core stalls delay dispatch; latency grows by the stall duration.
module ipc_interrupt_controller #(
  parameter int NUM_SRC = `IPC_NUM_SRC
) (
  input  wire logic                clk,          // 25 MHz system clock
  input  wire logic                rst_b,        // async reset, active low
  input  wire ipc_pkg::ipc_sfr_type sfrBus,      // register access from the core
  output logic [7:0]               sfrRdData,    // registered read data
  input  wire logic [NUM_SRC-1:0]  pendFlags,    // pending flags of the sources
  input  wire logic                cpuAck,       // core starts the far call
  input  wire logic                cpuRetDone,   // interrupt return retired
  input  wire logic                cpuInstrDone, // any instruction retired
  input  wire logic                cpuStall,     // core stalled by memory write or fifo move
  output ipc_pkg::ipc_req_type     irqReq        // registered request to the core
);
  logic [7:0]         mainEn;
  logic [7:0]         mainPrio;
  logic [7:0]         extEnA;
  logic [7:0]         extEnB;
  logic [7:0]         extPrioA;
  logic [7:0]         extPrioB;
  logic [NUM_SRC-1:0] enMask;
  logic [NUM_SRC-1:0] prioMask;
  logic [NUM_SRC-1:0] activeSet;
  logic [NUM_SRC-1:0] highSet;
  logic [NUM_SRC-1:0] lowSet;
  logic               inHigh;
  logic               inLow;
  logic               holdOne;
  logic               highOk;
  logic               lowOk;
  logic               blocked;
  ipc_pkg::ipc_req_type next_req;

  // lowest set index, the hardwired tie order
  function automatic logic [4:0] firstIdx(input logic [NUM_SRC-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) r = 5'(i);
    end
    return r;
  endfunction

  // entry address of a source
  function automatic logic [15:0] vecAddr(input logic [4:0] idx);
    return `IPC_VEC_BASE + (16'(idx) << `IPC_VEC_SHIFT);
  endfunction

  // mask of indices below idx, used by the order check
  function automatic logic [NUM_SRC-1:0] belowMask(input logic [4:0] idx);
    return (NUM_SRC'(1) << idx) - NUM_SRC'(1);
  endfunction

  // register writes; all levels default low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mainEn   <= `IPC_REG_RESET;
      mainPrio <= `IPC_REG_RESET;
      extEnA   <= `IPC_REG_RESET;
      extEnB   <= `IPC_REG_RESET;
      extPrioA <= `IPC_REG_RESET;
      extPrioB <= `IPC_REG_RESET;
    end else if (sfrBus.wrEn) begin
      unique case (sfrBus.addr)
        `IPC_OFS_MAIN_EN:    mainEn   <= sfrBus.wrData;
        `IPC_OFS_MAIN_PRIO:  mainPrio <= sfrBus.wrData;
        `IPC_OFS_EXT_EN_A:   extEnA   <= sfrBus.wrData;
        `IPC_OFS_EXT_EN_B:   extEnB   <= sfrBus.wrData;
        `IPC_OFS_EXT_PRIO_A: extPrioA <= sfrBus.wrData;
        `IPC_OFS_EXT_PRIO_B: extPrioB <= sfrBus.wrData;
        default: ;
      endcase
    end
  end

  // read back; other addresses belong to other blocks and read zero here
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sfrRdData <= 8'h00;
    end else if (sfrBus.rdEn) begin
      unique case (sfrBus.addr)
        `IPC_OFS_MAIN_EN:    sfrRdData <= mainEn;
        `IPC_OFS_MAIN_PRIO:  sfrRdData <= mainPrio;
        `IPC_OFS_EXT_EN_A:   sfrRdData <= extEnA;
        `IPC_OFS_EXT_EN_B:   sfrRdData <= extEnB;
        `IPC_OFS_EXT_PRIO_A: sfrRdData <= extPrioA;
        `IPC_OFS_EXT_PRIO_B: sfrRdData <= extPrioB;
        default:             sfrRdData <= 8'h00;
      endcase
    end
  end

  // per-source enable and priority vectors, one bit per source
  assign enMask   = NUM_SRC'({extEnB[2:0], extEnA, mainEn[`IPC_MAIN_SRC_CNT-1:0]});
  assign prioMask = NUM_SRC'({extPrioB[2:0], extPrioA, mainPrio[`IPC_MAIN_SRC_CNT-1:0]});
  // software-set and hardware-set flags are indistinguishable here
  assign activeSet = pendFlags & enMask & {NUM_SRC{mainEn[`IPC_GLOBAL_EN_BIT]}};
  assign highSet   = activeSet & prioMask;
  assign lowSet    = activeSet & ~prioMask;
  assign highOk    = !inHigh;
  assign lowOk     = !inHigh && !inLow;
  assign blocked   = holdOne || cpuStall;

  // decode every cycle; the registered result is the one detect clock
  always_comb begin
    next_req = irqReq;
    if ((irqReq.valid && cpuAck) || blocked) begin
      next_req.valid = 1'b0;
    end else if (highOk && |highSet) begin
      next_req.valid = 1'b1;
      next_req.level = ipc_pkg::LVL_HIGH;
      next_req.index = firstIdx(highSet);
      next_req.addr  = vecAddr(firstIdx(highSet));
    end else if (lowOk && |lowSet) begin
      next_req.valid = 1'b1;
      next_req.level = ipc_pkg::LVL_LOW;
      next_req.index = firstIdx(lowSet);
      next_req.addr  = vecAddr(firstIdx(lowSet));
    end else begin
      next_req.valid = 1'b0;
    end
  end

  // request register, refreshed each cycle so a new winner replaces an old one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqReq <= '0;
    end else begin
      irqReq <= next_req;
    end
  end

  // in-service levels; a return closes the highest level open
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      inHigh <= 1'b0;
      inLow  <= 1'b0;
    end else if (irqReq.valid && cpuAck) begin
      if (irqReq.level == ipc_pkg::LVL_HIGH) inHigh <= 1'b1;
      else inLow <= 1'b1;
    end else if (cpuRetDone) begin
      if (inHigh) inHigh <= 1'b0;
      else inLow <= 1'b0;
    end
  end

  // one instruction must follow a return; the return itself does not count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      holdOne <= 1'b0;
    end else if (cpuRetDone) begin
      holdOne <= 1'b1;
    end else if (cpuInstrDone) begin
      holdOne <= 1'b0;
    end
  end

  // properties beside the decode; they watch inputs, decode terms and registered state

  vector_map_a: assert property (@(posedge clk) disable iff (!rst_b)
    irqReq.valid |-> irqReq.addr == vecAddr(irqReq.index) && irqReq.index < 5'(NUM_SRC))
    else $error("vector address does not match source");
  detect_one_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!irqReq.valid && !blocked && highOk && |highSet) |=> irqReq.valid && irqReq.level)
    else $error("request not raised one clock after detect");
  stall_holds_a: assert property (@(posedge clk) disable iff (!rst_b)
    cpuStall |=> !irqReq.valid)
    else $error("request issued during core stall");
  return_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
    cpuRetDone ##1 !cpuInstrDone[*2] |=> !irqReq.valid)
    else $error("request before instruction after return");
  high_nopreempt_a: assert property (@(posedge clk) disable iff (!rst_b)
    inHigh |=> !irqReq.valid)
    else $error("high routine preempted");
  high_first_a: assert property (@(posedge clk) disable iff (!rst_b)
    irqReq.valid && irqReq.level == ipc_pkg::LVL_LOW |-> $past(highSet) == '0 || $past(inHigh))
    else $error("low request chosen over high");
  fixed_order_a: assert property (@(posedge clk) disable iff (!rst_b)
    irqReq.valid |-> ((irqReq.level ? $past(highSet) : $past(lowSet))
      & belowMask(irqReq.index)) == '0)
    else $error("lower index lost arbitration");
  equal_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
    (inLow && highSet == '0) |=> !irqReq.valid)
    else $error("equal level request during service");
  ack_drop_a: assert property (@(posedge clk) disable iff (!rst_b)
    (irqReq.valid && cpuAck) |=> !irqReq.valid ##1 (inHigh || inLow))
    else $error("accepted request not retired");

  // read back of the priority registers, one cycle after the strobe
  read_prio_a: assert property (@(posedge clk) disable iff (!rst_b)
    (sfrBus.rdEn && sfrBus.addr == `IPC_OFS_EXT_PRIO_A) |=> sfrRdData == $past(extPrioA))
    else $error("priority register a read back wrong");

  // second extended priority register
  read_prio_b_a: assert property (@(posedge clk) disable iff (!rst_b)
    (sfrBus.rdEn && sfrBus.addr == `IPC_OFS_EXT_PRIO_B) |=> sfrRdData == $past(extPrioB))
    else $error("priority register b read back wrong");

  // main priority register
  read_main_prio_a: assert property (@(posedge clk) disable iff (!rst_b)
    (sfrBus.rdEn && sfrBus.addr == `IPC_OFS_MAIN_PRIO) |=> sfrRdData == $past(mainPrio))
    else $error("main priority read back wrong");

  // extended enable register read back
  read_enable_a: assert property (@(posedge clk) disable iff (!rst_b)
    (sfrBus.rdEn && sfrBus.addr == `IPC_OFS_EXT_EN_A) |=> sfrRdData == $past(extEnA))
    else $error("enable register a read back wrong");

  // unmapped addresses belong to other blocks and read zero
  read_unmapped_a: assert property (@(posedge clk) disable iff (!rst_b)
    (sfrBus.rdEn && !(sfrBus.addr inside {`IPC_OFS_MAIN_EN, `IPC_OFS_MAIN_PRIO,
      `IPC_OFS_EXT_EN_A, `IPC_OFS_EXT_EN_B, `IPC_OFS_EXT_PRIO_A, `IPC_OFS_EXT_PRIO_B}))
      |=> sfrRdData == 8'h00)
    else $error("unmapped address read nonzero");

  // read data holds between strobes
  read_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !sfrBus.rdEn |=> $stable(sfrRdData))
    else $error("read data changed without strobe");

  // priority write lands the next cycle
  write_prio_a: assert property (@(posedge clk) disable iff (!rst_b)
    (sfrBus.wrEn && sfrBus.addr == `IPC_OFS_EXT_PRIO_B) |=> extPrioB == $past(sfrBus.wrData))
    else $error("priority register b write lost");

  // first extended priority write
  write_prio_one_a: assert property (@(posedge clk) disable iff (!rst_b)
    (sfrBus.wrEn && sfrBus.addr == `IPC_OFS_EXT_PRIO_A) |=> extPrioA == $past(sfrBus.wrData))
    else $error("priority register a write lost");

  // main enable write, global enable included
  write_enable_a: assert property (@(posedge clk) disable iff (!rst_b)
    (sfrBus.wrEn && sfrBus.addr == `IPC_OFS_MAIN_EN) |=> mainEn == $past(sfrBus.wrData))
    else $error("main enable write lost");

  // upper sources enable write
  write_en_b_a: assert property (@(posedge clk) disable iff (!rst_b)
    (sfrBus.wrEn && sfrBus.addr == `IPC_OFS_EXT_EN_B) |=> extEnB == $past(sfrBus.wrData))
    else $error("enable register b write lost");

  // global enable off silences every source, software flags too
  global_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    !mainEn[`IPC_GLOBAL_EN_BIT] |=> !irqReq.valid)
    else $error("request with global enable off");

  // the shown source was pending and enabled one clock earlier
  source_live_a: assert property (@(posedge clk) disable iff (!rst_b)
    irqReq.valid |-> |($past(activeSet) & (NUM_SRC'(1) << irqReq.index)))
    else $error("request for a source not active");

  // shown level agrees with that source's priority bit
  level_match_a: assert property (@(posedge clk) disable iff (!rst_b)
    irqReq.valid |-> ((irqReq.level == ipc_pkg::LVL_HIGH)
      == |($past(prioMask) & (NUM_SRC'(1) << irqReq.index))))
    else $error("request level differs from priority bit");

  // any open routine shuts out every non-high request
  service_block_a: assert property (@(posedge clk) disable iff (!rst_b)
    ((inHigh || inLow) && highSet == '0) |=> !irqReq.valid)
    else $error("request while routine open and no high source");

  // a return arms the one-instruction wait
  hold_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    cpuRetDone |=> holdOne)
    else $error("return did not arm instruction wait");

  // the next retired instruction ends the wait
  hold_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    (holdOne && cpuInstrDone && !cpuRetDone) |=> !holdOne)
    else $error("instruction wait not released");

  // a return closes the open high level first
  ret_closes_a: assert property (@(posedge clk) disable iff (!rst_b)
    (inHigh && cpuRetDone && !(irqReq.valid && cpuAck)) |=> !inHigh)
    else $error("return left high level open");

  // accepting a high request opens the high level
  ack_high_a: assert property (@(posedge clk) disable iff (!rst_b)
    (irqReq.valid && cpuAck && irqReq.level == ipc_pkg::LVL_HIGH) |=> inHigh)
    else $error("high level not opened on accept");

  // accepting a low request opens the low level
  ack_low_a: assert property (@(posedge clk) disable iff (!rst_b)
    (irqReq.valid && cpuAck && irqReq.level == ipc_pkg::LVL_LOW) |=> inLow)
    else $error("low level not opened on accept");

  // no request is shown that was decoded during a stall or wait
  decode_free_a: assert property (@(posedge clk) disable iff (!rst_b)
    irqReq.valid |-> $past(!blocked))
    else $error("request decoded while blocked");

  // a high source with no high routine open always wins the level
  high_wins_a: assert property (@(posedge clk) disable iff (!rst_b)
    (irqReq.valid && $past(highSet) != '0 && !$past(inHigh)) |-> irqReq.level == ipc_pkg::LVL_HIGH)
    else $error("high source lost to low");
endmodule // ipc_interrupt_controller
`default_nettype wire

// >>> bench/ipc_core_model.sv
// behavioural core sequencer answering the controller's requests
`timescale 1ns/1ns
`default_nettype none
module ipc_core_model (
  input  wire logic                 clk,    // system clock
  input  wire logic                 rst_b,  // async reset, active low
  input  wire logic                 ackEn,  // bench lets the core take requests
  input  wire ipc_pkg::ipc_req_type irqReq, // request from the controller
  output logic                      cpuAck  // far call begins
);
  // one-cycle ack; ackEn low models a slow core that leaves a request standing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpuAck <= 1'b0;
    end else begin
      cpuAck <= irqReq.valid && ackEn && !cpuAck;
    end
  end
endmodule // ipc_core_model
`default_nettype wire

// >>> bench/test_interrupt_priority_controller.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module test_interrupt_priority_controller;
  logic                 clk = 1'b0;
  logic                 rst_b = 1'b0;
  ipc_pkg::ipc_sfr_type sfrBus = '0;
  logic [7:0]           sfrRdData;
  logic [17:0]          pendFlags = '0;
  logic                 cpuAck;
  logic                 cpuRetDone = 1'b0;
  logic                 cpuInstrDone = 1'b0;
  logic                 cpuStall = 1'b0;
  logic                 ackEn = 1'b0;
  ipc_pkg::ipc_req_type irqReq;
  int                   failures = 0;
  int                   total_checks = 0;
  logic [7:0]           regOfs [4] = '{8'he6, 8'he7, 8'hf6, 8'hf7};
  // 25 MHz clock
  always #20 clk = ~clk;
  ipc_interrupt_controller dut (.clk(clk), .rst_b(rst_b), .sfrBus(sfrBus),
    .sfrRdData(sfrRdData), .pendFlags(pendFlags), .cpuAck(cpuAck), .cpuRetDone(cpuRetDone),
    .cpuInstrDone(cpuInstrDone), .cpuStall(cpuStall), .irqReq(irqReq));
  ipc_core_model core (.clk(clk), .rst_b(rst_b), .ackEn(ackEn), .irqReq(irqReq), .cpuAck(cpuAck));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic sfrWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfrBus <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(posedge clk);
    sfrBus <= '0;
  endtask
  task automatic sfrRead(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfrBus <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
    @(posedge clk);
    sfrBus <= '0;
    #1 d = sfrRdData;
  endtask
  // address is worked out from base 0x0003 and a step of 8
  task automatic reqIs(input logic v, input logic [4:0] idx, input logic lvl);
    check({15'h0000, irqReq.valid}, {15'h0000, v});
    if (v) begin
      check({15'h0000, irqReq.level}, {15'h0000, lvl});
      check({11'h000, irqReq.index}, {11'h000, idx});
      check(irqReq.addr, 16'h0003 + {8'h00, idx, 3'b000});
    end
  endtask
  // bounded wait, so a missing request shows as a mismatch, not a hang
  task automatic waitReq;
    int n;
    n = 0;
    while (irqReq.valid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  // let the core take the standing request, then drop serviced flags
  task automatic takeReq(input logic [17:0] left);
    @(posedge clk);
    ackEn <= 1'b1;
    repeat (2) @(posedge clk);
    ackEn <= 1'b0;
    pendFlags <= left;
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
  initial begin
    logic [7:0] rd;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    foreach (regOfs[i]) begin
      sfrRead(regOfs[i], rd);
      check({8'h00, rd}, 16'h0000);
    end
    sfrWrite(8'he6, 8'hff);
    sfrWrite(8'h10, 8'h5a);
    sfrRead(8'he6, rd);
    check({8'h00, rd}, 16'h00ff);
    sfrRead(8'h10, rd);
    check({8'h00, rd}, 16'h0000);
    $display("test registers done");
    // source 3 and 17 high, 9 and 12 low, global enable set
    sfrWrite(8'ha8, 8'h88);
    sfrWrite(8'hb8, 8'h08);
    sfrWrite(8'he6, 8'h24);
    sfrWrite(8'he7, 8'h04);
    sfrWrite(8'hf7, 8'h04);
    sfrRead(8'hf7, rd);
    check({8'h00, rd}, 16'h0004);
    @(posedge clk);
    pendFlags <= 18'h21200;
    @(posedge clk);
    #1 reqIs(1'b1, 5'd17, 1'b1);
    @(posedge clk);
    cpuStall <= 1'b1;
    @(posedge clk);
    #1 reqIs(1'b0, 5'd0, 1'b0);
    @(posedge clk);
    cpuStall <= 1'b0;
    @(posedge clk);
    #1 reqIs(1'b1, 5'd17, 1'b1);
    $display("test arbitration done");
    takeReq(18'h01200);
    @(posedge clk);
    #1 reqIs(1'b0, 5'd0, 1'b0);
    @(posedge clk);
    cpuRetDone <= 1'b1;
    @(posedge clk);
    cpuRetDone <= 1'b0;
    @(posedge clk);
    #1 reqIs(1'b0, 5'd0, 1'b0);
    @(posedge clk);
    cpuInstrDone <= 1'b1;
    @(posedge clk);
    cpuInstrDone <= 1'b0;
    waitReq();
    reqIs(1'b1, 5'd9, 1'b0);
    takeReq(18'h01000);
    @(posedge clk);
    #1 reqIs(1'b0, 5'd0, 1'b0);
    @(posedge clk);
    pendFlags <= 18'h01008;
    @(posedge clk);
    #1 reqIs(1'b1, 5'd3, 1'b1);
    $display("test service levels done");
    print_verdict();
  end
endmodule // test_interrupt_priority_controller
`default_nettype wire
